// ### hdl/dram_host.sv
// controller for a 4096 x 1 dynamic memory with multiplexed address pins
// assumes the memory pins are wired straight to the strobe outputs and
// that its data output is sampled synchronously to clk
//
// Notes on behaviour
// - every row is refreshed at least once per 2 ms period
// - chip select stays inactive when no cell is being accessed
// - twelve address bits go out as row then column on six pins
// - row strobe never stays active beyond 10,000 ns
// - row strobe stays inactive at least 80 ns between row cycles
// - eight refresh cycles are done after power up before use
`timescale 1ns/1ps
module dram_host
	import dram_host_pkg::*;
#(
	parameter int REFRESH_PERIOD_CYC = REFRESH_PERIOD_CYC_DOC
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire logic              req_write,
	input  wire logic              req_rmw,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic              req_wdata,
	output logic                   rsp_valid,
	output logic                   rsp_rdata,
	output logic                   init_done,
	output logic                   row_strobe_n,
	output logic                   col_strobe_n,
	output logic                   write_strobe_n,
	output logic                   chip_sel_n,
	output logic [MUX_W-1:0]       mux_addr_pins,
	output logic                   dram_din,
	input  wire logic              dram_dout
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	state_type        state_q, state_d;
	logic [1:0]       wait_q, wait_d;
	logic [6:0]       ras_cnt_q, ras_cnt_d;
	logic [MUX_W-1:0] row_q, col_q, ref_row_q;
	logic [MUX_W-1:0] addr_d;
	logic             wr_q, rmw_q;
	logic             ref_pend_q;
	logic [3:0]       init_cnt_q;
	logic             ref_tick;

	// ---------------------------------------------------------------
	// refresh slot timer
	// ---------------------------------------------------------------
	refresh_timer #(
		.INTERVAL_CYC (REFRESH_PERIOD_CYC / ROWS)
	) u_refresh_timer (
		.clk  (clk),
		.rst  (rst),
		.tick (ref_tick)
	);

	// ---------------------------------------------------------------
	// request decode
	// ---------------------------------------------------------------
	wire [MUX_W-1:0] req_row   = req_addr[ADDR_W-1:ROW_LSB];
	wire [MUX_W-1:0] req_col   = req_addr[ROW_LSB-1:0];
	wire             wait_done = (wait_q == 2'h0);
	wire             in_idle   = (state_q == S_IDLE);
	// refreshes go first; before init they are forced
	wire ref_start = in_idle && (ref_pend_q || !init_done);
	wire idle_ok   = in_idle && init_done && !ref_pend_q;
	// the row may stay open only while the strobe limit leaves room
	wire row_end   = (state_q == S_CAS && wait_done && !rmw_q) ||
		(state_q == S_RMW);
	wire page_ok   = row_end && !ref_pend_q && (req_row == row_q) &&
		(ras_cnt_q < RAS_LIMIT);
	wire take      = req_valid && (idle_ok || page_ok);
	wire ras_low   = (state_d == S_RAS) || (state_d == S_COL) ||
		(state_d == S_CAS) || (state_d == S_RMW) || (state_d == S_REF);
	wire cas_low   = (state_d == S_CAS) || (state_d == S_RMW);
	// chip select only around a real access, never for refresh
	wire sel_low   = (state_d == S_COL) || cas_low;
	wire wr_d      = take ? (req_write && !req_rmw) : wr_q;
	wire rmw_d     = take ? req_rmw : rmw_q;
	// early write drops before the column strobe; delayed one after it
	wire we_low    = (((state_d == S_COL) || (state_d == S_CAS)) && wr_d)
		|| (state_d == S_RMW);

	assign req_ready = idle_ok || page_ok;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_IDLE: begin
				if (ref_start) begin
					state_d = S_REF;
				end else if (take) begin
					state_d = S_ROW;
				end
			end
			S_ROW: state_d = S_RAS;
			S_RAS: state_d = S_COL;
			S_COL: state_d = S_CAS;
			S_CAS: begin
				if (wait_done) begin
					if (rmw_q) begin
						state_d = S_RMW;
					end else if (take) begin
						state_d = S_COL;
					end else begin
						state_d = S_PRE;
					end
				end
			end
			S_RMW: state_d = take ? S_COL : S_PRE;
			S_REF: state_d = wait_done ? S_PRE : S_REF;
			S_PRE: state_d = wait_done ? S_IDLE : S_PRE;
		endcase
	end

	// wait loads on entry, counts down while the state holds
	always_comb begin
		wait_d = (wait_q != 2'h0) ? wait_q - 2'h1 : 2'h0;
		if (state_d != state_q) begin
			unique case (state_d)
				S_CAS:   wait_d = CAS_W;
				S_REF:   wait_d = REF_W;
				S_PRE:   wait_d = RP_W;
				default: wait_d = 2'h0;
			endcase
		end
	end

	// address mux: row phase, then column phase, refresh row for refresh
	always_comb begin
		addr_d = mux_addr_pins;
		if (ref_start) begin
			addr_d = ref_row_q;
		end else if (take && in_idle) begin
			addr_d = req_row;
		end else if (take) begin
			addr_d = req_col;
		end else if (state_q == S_RAS) begin
			addr_d = col_q;
		end
	end

	assign ras_cnt_d = ras_low ? ras_cnt_q + 7'h01 : 7'h00;

	// ---------------------------------------------------------------
	// sequencer registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q   <= S_IDLE;
			wait_q    <= 2'h0;
			ras_cnt_q <= 7'h00;
			row_q     <= 6'h00;
			col_q     <= 6'h00;
			wr_q      <= 1'b0;
			rmw_q     <= 1'b0;
		end else begin
			state_q   <= state_d;
			wait_q    <= wait_d;
			ras_cnt_q <= ras_cnt_d;
			wr_q      <= wr_d;
			rmw_q     <= rmw_d;
			if (take && in_idle) begin
				row_q <= req_row;
			end
			if (take) begin
				col_q <= req_col;
			end
		end
	end

	// ---------------------------------------------------------------
	// pin registers: strobes follow the next state so they are glitch free
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			row_strobe_n   <= 1'b1;
			col_strobe_n   <= 1'b1;
			write_strobe_n <= 1'b1;
			chip_sel_n     <= 1'b1;
			mux_addr_pins  <= 6'h00;
			dram_din       <= 1'b0;
		end else begin
			row_strobe_n   <= !ras_low;
			col_strobe_n   <= !cas_low;
			write_strobe_n <= !we_low;
			chip_sel_n     <= !sel_low;
			mux_addr_pins  <= addr_d;
			if (take) begin
				dram_din <= req_wdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// read data: sampled once the column access time has passed
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= 1'b0;
		end else begin
			rsp_valid <= (state_q == S_CAS) && wait_done && !wr_q;
			if ((state_q == S_CAS) && wait_done && !wr_q) begin
				rsp_rdata <= dram_dout;
			end
		end
	end

	// ---------------------------------------------------------------
	// refresh bookkeeping; a new slot wins over the clear
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_pend_q <= 1'b0;
			ref_row_q  <= 6'h00;
			init_cnt_q <= 4'h0;
			init_done  <= 1'b0;
		end else begin
			ref_pend_q <= ref_tick || (ref_pend_q && !ref_start);
			if (ref_start) begin
				ref_row_q <= ref_row_q + 6'h01;
			end
			if (ref_start && init_cnt_q != INIT_COUNT) begin
				init_cnt_q <= init_cnt_q + 4'h1;
			end
			if (state_q == S_PRE && wait_done && init_cnt_q == INIT_COUNT) begin
				init_done <= 1'b1;
			end
		end
	end

endmodule // dram_host

// ### hdl/dram_host_pkg.sv
// constants shared by the multiplexed dynamic memory controller
// assumes a 10 MHz system clock and the fastest device speed grade
package dram_host_pkg;

	// -------------------------------------------------------------
	// clock and geometry
	// -------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int ADDR_W        = 12;
	localparam int MUX_W         = 6;
	localparam int ROWS          = 64;
	localparam int ROW_LSB       = 6;

	// -------------------------------------------------------------
	// timing in nanoseconds (refresh period in ms), as specified
	// -------------------------------------------------------------
	localparam int ROW_PRECHARGE_TIME_NS = 80;
	localparam int RAS_MIN_NS            = 120;
	localparam int RAS_MAX_NS            = 10000;
	localparam int CAS_MIN_NS            = 80;
	localparam int COLUMN_ACCESS_TIME_NS = 80;
	localparam int REFRESH_PERIOD_MS     = 2;
	localparam int INIT_REFRESHES        = 8;

	// -------------------------------------------------------------
	// derived cycle counts: least times round up, longest round down
	// -------------------------------------------------------------
	localparam int RP_RAW  = (ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int RP_CYC  = (RP_RAW < 1) ? 1 : RP_RAW;
	localparam int RMIN_RAW = (RAS_MIN_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int RAS_MIN_CYC = (RMIN_RAW < 1) ? 1 : RMIN_RAW;
	localparam int CMIN_RAW = (CAS_MIN_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CAC_RAW = (COLUMN_ACCESS_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CAS_RAW = (CMIN_RAW > CAC_RAW) ? CMIN_RAW : CAC_RAW;
	localparam int CAS_CYC = (CAS_RAW < 1) ? 1 : CAS_RAW;
	localparam int RAS_MAX_CYC = RAS_MAX_NS / CLK_PERIOD_NS;
	// cycles one more page access keeps the row strobe low
	localparam int PAGE_COST_CYC = CAS_CYC + 2;
	localparam int REFRESH_PERIOD_CYC_DOC =
		REFRESH_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

	// wait counter loads, row span limit and warm-up refresh count
	localparam logic [1:0] RP_W   = 2'(RP_CYC - 1);
	localparam logic [1:0] REF_W  = 2'(RAS_MIN_CYC - 1);
	localparam logic [1:0] CAS_W  = 2'(CAS_CYC - 1);
	localparam logic [6:0] RAS_LIMIT = 7'(RAS_MAX_CYC - PAGE_COST_CYC);
	localparam logic [3:0] INIT_COUNT = 4'(INIT_REFRESHES);

	// -------------------------------------------------------------
	// sequencer states
	// -------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_ROW  = 3'h1,
		S_RAS  = 3'h2,
		S_COL  = 3'h3,
		S_CAS  = 3'h4,
		S_RMW  = 3'h5,
		S_REF  = 3'h6,
		S_PRE  = 3'h7
	} state_type;

endpackage

// ### hdl/refresh_timer.sv
// refresh interval timer: one pulse per row refresh slot
// assumes a free running clock and an asynchronous active high reset
`timescale 1ns/1ps
module refresh_timer #(
	parameter int INTERVAL_CYC = 312
) (
	input  wire logic clk,
	input  wire logic rst,
	output logic      tick
);

	localparam logic [15:0] LOAD = 16'(INTERVAL_CYC - 1);

	logic [15:0] count_q;
	wire         at_zero = (count_q == 16'h0000);

	// down counter; reaching zero reloads it and raises the slot pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_q <= 16'h0000;
			tick    <= 1'b0;
		end else begin
			count_q <= at_zero ? LOAD : count_q - 16'h0001;
			tick    <= at_zero;
		end
	end

endmodule // refresh_timer

// ### verification/dram_host_asserts.sv
// pin checker for the dynamic memory controller
// assumes it is bound onto dram_host and sees only its ports
`timescale 1ns/1ps
module dram_host_asserts
	import dram_host_pkg::*;
#(
	parameter int REFRESH_PERIOD_CYC = 640
) (
	input wire logic             clk,
	input wire logic             rst,
	input wire logic             req_ready,
	input wire logic             init_done,
	input wire logic             row_strobe_n,
	input wire logic             col_strobe_n,
	input wire logic             chip_sel_n,
	input wire logic [MUX_W-1:0] mux_addr_pins
);
	localparam int REF_WIN = REFRESH_PERIOD_CYC;
	logic [3:0] falls_q;

	// row strobe falls since reset; saturates so it cannot wrap
	always_ff @(posedge clk or posedge rst)
		if (rst)
			falls_q <= 4'h0;
		else if ($fell(row_strobe_n) && falls_q != 4'hF)
			falls_q <= falls_q + 4'h1;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// strobe order, spans and power-up sequence
	property p_pre; $rose(row_strobe_n) |=> row_strobe_n; endproperty
	a_pre: assert property (p_pre) else $error("short precharge");
	property p_ras; $fell(row_strobe_n) |-> ##[1:100] row_strobe_n; endproperty
	a_ras: assert property (p_ras) else $error("row too long");
	property p_lead;
		!col_strobe_n |-> !row_strobe_n && !$past(row_strobe_n);
	endproperty
	a_lead: assert property (p_lead) else $error("column first");
	property p_sel; !chip_sel_n |-> !row_strobe_n; endproperty
	a_sel: assert property (p_sel) else $error("stray select");
	property p_addr;
		$fell(col_strobe_n) |-> $stable(mux_addr_pins) && $stable(chip_sel_n);
	endproperty
	a_addr: assert property (p_addr) else $error("column moved");
	property p_init; !init_done |-> !req_ready && col_strobe_n; endproperty
	a_init: assert property (p_init) else $error("early access");
	property p_cnt; $rose(init_done) |-> falls_q >= 4'h8; endproperty
	a_cnt: assert property (p_cnt) else $error("few refreshes");
	property p_ref;
		$rose(row_strobe_n) |-> ##[1:REF_WIN] $fell(row_strobe_n);
	endproperty
	a_ref: assert property (p_ref) else $error("refresh gap");
endmodule // dram_host_asserts

bind dram_host dram_host_asserts #(
	.REFRESH_PERIOD_CYC(REFRESH_PERIOD_CYC)
) u_chk (.clk, .rst, .req_ready, .init_done, .row_strobe_n,
	.col_strobe_n, .chip_sel_n, .mux_addr_pins);

// ### verification/dram_host_tb.sv
// self-checking bench for the dynamic memory controller
// assumes the memory model and the bound pin checker
`timescale 1ns/1ps
module dram_host_tb
	import dram_host_pkg::*;
;
	logic              clk = 1'b0, rst = 1'b1, req_valid = 1'b0;
	logic              req_write = 1'b0, req_rmw = 1'b0, req_wdata = 1'b0;
	logic [ADDR_W-1:0] req_addr = 12'h000, a = 12'h000;
	logic [ADDR_W-1:0] corner [4] = '{12'h000, 12'hFFF, 12'h03F, 12'hFC0};
	wire               req_ready, rsp_valid, rsp_rdata, init_done;
	wire               row_strobe_n, col_strobe_n, write_strobe_n;
	wire               chip_sel_n, dram_din, dram_dout;
	wire [MUX_W-1:0]   mux_addr_pins;
	int                miscompares = 0, checks_done = 0, faults, falls = 0;
	logic              ref_mem [4096];
	logic              exp_q [$];
	bit [31:0]         seed = 62, r;

	// short refresh period keeps the run brief: 10 cycles a row slot
	dram_host #(.REFRESH_PERIOD_CYC(640)) DUT (.clk, .rst, .req_valid,
		.req_ready, .req_write, .req_rmw, .req_addr, .req_wdata, .rsp_valid,
		.rsp_rdata, .init_done, .row_strobe_n, .col_strobe_n,
		.write_strobe_n, .chip_sel_n, .mux_addr_pins, .dram_din, .dram_dout);
	// margin of one longest row span over the shortened period
	dram_model #(.REFRESH_NS(74000)) mem_u (.row_strobe_n, .col_strobe_n,
		.write_strobe_n, .chip_sel_n, .mux_addr_pins, .dram_din, .dram_dout,
		.faults);

	initial forever #50 clk = ~clk;

	function automatic bit [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic note(input bit bad, input logic [31:0] got, exp);
		checks_done++;
		if (bad) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		note(got !== exp, 32'(got), 32'(exp));
	endtask
	task automatic chk_cnt(input int got, input int exp);
		note(got != exp, got, exp);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// release reset, then no request may be taken until warm-up ends
	task automatic do_reset();
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		falls = 0;
		for (int i = 0; i < 80 && init_done !== 1'b1; i++) begin
			chk_bit(req_ready, 1'b0);
			@(posedge clk);
			#1;
		end
		chk_bit(init_done, 1'b1);
		chk_cnt(int'(falls >= 8), 1);
	endtask

	// kind 0 read, 1 early write, 2 read-modify-write; valid is held
	// between calls so it is never set twice in one step
	task automatic issue(input int k, input logic [ADDR_W-1:0] ad,
		input logic d);
		logic ok = 1'b0;
		req_valid = 1'b1;
		req_write = 1'(k == 1);
		req_rmw = 1'(k == 2);
		req_addr = ad;
		req_wdata = d;
		for (int n = 0; n < 300 && ok !== 1'b1; n++) begin
			@(negedge clk) ok = (req_ready === 1'b1);
			@(posedge clk);
		end
		if (ok !== 1'b1) chk_cnt(0, 1);
		if (k != 1) exp_q.push_back(ref_mem[ad]);
		if (k != 0) ref_mem[ad] = d;
		#1;
	endtask

	task automatic idle();
		req_valid = 1'b0;
		repeat (8) @(posedge clk);
		#1;
	endtask

	// each answer pairs with the oldest outstanding read
	always @(negedge clk)
		if (!rst && rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) chk_cnt(1, 0);
			else chk_bit(rsp_rdata, exp_q.pop_front());
		end

	always @(negedge row_strobe_n) falls++;

	// traffic needs about 4000 cycles; 20000 means a hang
	initial begin
		#2ms;
		miscompares++;
		end_of_test();
	end

	initial begin
		foreach (ref_mem[i]) ref_mem[i] = 1'b0;
		do_reset();
		foreach (corner[i]) issue(1, corner[i], 1'b1);
		foreach (corner[i]) issue(0, corner[i], 1'b0);
		foreach (corner[i]) issue(2, corner[i], 1'b0);
		for (int i = 0; i < 60; i++) begin
			r = rnd();
			issue(0, {6'h2A, r[5:0]}, 1'b0);
		end
		for (int i = 0; i < 300; i++) begin
			r = rnd();
			a = r[3] ? {a[11:6], r[25:20]} : r[31:20];
			issue(int'(r[1:0]) % 3, a, r[8]);
		end
		// read every row in ascending order just before the mid-run reset:
		// the reset restarts the refresh row counter at zero, so each row
		// must be fresh enough to wait out one full sweep after release
		for (int i = 0; i < ROWS; i++) begin
			issue(0, {6'(i), 6'h00}, 1'b0);
		end
		idle();
		rst = 1'b1;
		do_reset();
		foreach (corner[i]) issue(0, corner[i], 1'b0);
		idle();
		chk_cnt(faults, 0);
		chk_cnt(exp_q.size(), 0);
		end_of_test();
	end
endmodule // dram_host_tb

// ### verification/dram_model.sv
// behavioural 4096 x 1 dynamic memory at the controller pins
// assumes one controller drives every strobe, low active
`timescale 1ns/1ps
module dram_model #(
	parameter int REFRESH_NS = 74000
) (
	input  wire logic       row_strobe_n,
	input  wire logic       col_strobe_n,
	input  wire logic       write_strobe_n,
	input  wire logic       chip_sel_n,
	input  wire logic [5:0] mux_addr_pins,
	input  wire logic       dram_din,
	output logic            dram_dout,
	output int              faults
);
	logic       cells [4096];
	logic [5:0] row_q, col_q;
	logic       sel_q = 1'b1;
	time        last [64];
	time        fall_t = 0, rise_t = 0;
	int         n = 0;

	// contents start cleared so the bench knows them
	initial begin
		faults = 0;
		dram_dout = 1'b0;
		foreach (cells[i]) cells[i] = 1'b0;
		foreach (last[i]) last[i] = 0;
	end

	// end of a row span
	always @(posedge row_strobe_n) begin
		if ($time - fall_t > 10000) faults++;
		rise_t = $time;
	end

	// row latch; any row cycle refreshes its row; address is taken
	// inside its hold window since it may move on the same edge
	always @(negedge row_strobe_n) begin
		if ($time - rise_t < 80) faults++;
		fall_t = $time;
		n++;
		#1;
		row_q = mux_addr_pins;
		if (last[row_q] != 0 && $time - last[row_q] > REFRESH_NS) faults++;
		last[row_q] = $time;
	end

	// column latch; the old bit is gone before the access time
	always @(negedge col_strobe_n) begin
		if (row_strobe_n !== 1'b0 || n < 8) faults++;
		col_q = mux_addr_pins;
		sel_q = chip_sel_n;
		dram_dout = ~dram_dout;
		if (!sel_q && !write_strobe_n)
			cells[{row_q, col_q}] = dram_din;
		#80;
		if (!sel_q)
			dram_dout = cells[{row_q, col_q}];
	end

	// late write keeps the bit read earlier in the latch
	always @(negedge write_strobe_n)
		if (!col_strobe_n && !sel_q)
			cells[{row_q, col_q}] = dram_din;
endmodule // dram_model
